/* File: inc/mgcp_pkg.sv */
// package: register map, field layout and timing constants of the pad port block
package mgcp_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned BUZZ_TONE_HZ    = 2_000;
  localparam int unsigned CAM_CLK_HZ      = 1_000_000;
  localparam int unsigned BUZZ_HALF_CYC   = CLK_HZ / (2 * BUZZ_TONE_HZ);
  localparam int unsigned CAM_HALF_CYC    = CLK_HZ / (2 * CAM_CLK_HZ);
  localparam int          DIV_W           = 16;

  localparam logic [11:0] ADDR_MODE       = 12'h000;
  localparam logic [11:0] ADDR_OUT        = 12'h004;
  localparam logic [11:0] ADDR_IN         = 12'h008;
  localparam logic [11:0] ADDR_ALT_CTL    = 12'h00C;
  localparam logic [11:0] ADDR_CAM_CTL    = 12'h010;
  localparam logic [11:0] ADDR_CAM_STAT   = 12'h014;
  localparam logic [11:0] ADDR_BUZZ_DIV   = 12'h018;

  localparam int          NPAD            = 3;

  // per pad mode field, two bits each
  localparam logic [1:0]  MODE_IN         = 2'h0;
  localparam logic [1:0]  MODE_OUT        = 2'h1;
  localparam logic [1:0]  MODE_ALT        = 2'h2;

  // alternate control register bits
  localparam int          ALT_RADIO_BIT   = 0;
  localparam int          ALT_ALARM_SET   = 1;
  localparam int          ALT_ALARM_CLR   = 2;
  localparam int          ALT_BUZZ_EN     = 3;
  localparam int          ALT_ALARM_STAT  = 4;

  // camera control / status bits
  localparam int          CAM_PWR_BIT     = 0;
  localparam int          CAM_CLK_EN_BIT  = 1;
  localparam int          CAM_FRAME_BIT   = 8;
  localparam int          CAM_READY_BIT   = 9;

  localparam logic [5:0]  MODE_RESET      = 6'h00;
  localparam logic [DIV_W-1:0] BUZZ_DIV_RESET = DIV_W'(BUZZ_HALF_CYC);

  typedef struct packed {
    logic [NPAD-1:0] out;
    logic [NPAD-1:0] oe_n;
  } mgcp_pad_drive_s;

  typedef struct packed {
    logic       frame_end;
    logic       data_ready;
    logic [7:0] data;
  } mgcp_cam_in_s;

endpackage

/* File: hw/mgcp_top.sv */
// pad port block: three multi-mode pads, camera side pins, apb registers
//
// Operation
// - each pad selects input, output or internally driven alternate function
// - input-mode pad read returns current pad level
// - output-mode pad takes written level; read returns set value
// - alternate-mode pad level comes from internal logic, not user writes
// - pad zero alternate function is the radio transmit monitor
// - alarm pad offers input, output and alarm output
// - buzzer pad offers input, output and buzzer drive
// - output pads drive both levels actively
// - alarm output rises at alarm start, falls on clear command
// - buzzer output produces square waves when enabled
// - camera frame end strobe is received as an input
// - module supplies the camera clock on its clock output pad
// - camera data ready is sampled and qualifies parallel data
// - module drives the camera power command output
`timescale 1ns/100ps
module mgcp_top
  import mgcp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        radio_transmit_monitor,
  input  wire logic        alarm_start,
  input  wire logic [NPAD-1:0] pad_in,
  output logic      [NPAD-1:0] pad_out,
  output logic      [NPAD-1:0] pad_oe_n,
  input  wire logic        frame_end_input,
  input  wire logic        camera_data_ready_in,
  input  wire logic [7:0]  parallel_data_in,
  output logic             camera_clock_out,
  output logic             camera_power_command
);

  // register state
  logic [5:0]       mode_r;
  logic [NPAD-1:0]  out_r;
  logic             radio_en_r;
  logic             alarm_r;
  logic             buzz_en_r;
  logic             buzz_r;
  logic [DIV_W-1:0] buzz_div_r;
  logic [DIV_W-1:0] buzz_cnt_r;
  logic             cam_pwr_r;
  logic             cam_clk_en_r;
  logic             cam_clk_r;
  logic [DIV_W-1:0] cam_cnt_r;
  logic             frame_d_r;
  logic             frame_seen_r;
  logic [7:0]       cam_data_r;

  // pin synchronisers
  logic [NPAD-1:0]  pin_s1_r;
  logic [NPAD-1:0]  pin_s2_r;
  logic             frame_s1_r;
  logic             frame_s2_r;
  logic             ready_s1_r;
  logic             ready_s2_r;
  logic [7:0]       data_s1_r;
  logic [7:0]       data_s2_r;

  // bus decode
  logic [31:0]      prdata_nxt;
  logic             acc;
  logic             wr;
  logic             rd;
  logic             rd_setup;
  logic             hit_mode;
  logic             hit_out;
  logic             hit_in;
  logic             hit_alt;
  logic             hit_cam;
  logic             hit_stat;
  logic             hit_div;
  logic             mapped;
  logic             alt_wr;
  logic             stat_rd;

  // internal events
  logic             frame_rise;
  logic             buzz_wrap;
  logic             cam_wrap;
  logic             radio_alt;
  logic             alarm_set;
  logic             alarm_clr;
  logic [NPAD-1:0]  alt_val;

  // apb decode: zero wait states, unmapped offsets flag an error
  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign rd       = acc & ~pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign hit_mode = (paddr == ADDR_MODE);
  assign hit_out  = (paddr == ADDR_OUT);
  assign hit_in   = (paddr == ADDR_IN);
  assign hit_alt  = (paddr == ADDR_ALT_CTL);
  assign hit_cam  = (paddr == ADDR_CAM_CTL);
  assign hit_stat = (paddr == ADDR_CAM_STAT);
  assign hit_div  = (paddr == ADDR_BUZZ_DIV);
  assign mapped   = hit_mode | hit_out | hit_in | hit_alt | hit_cam | hit_stat | hit_div;
  assign pslverr  = acc & ~mapped;
  assign alt_wr   = wr & hit_alt;
  assign stat_rd  = rd & hit_stat;

  // pad pins are asynchronous: two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= pad_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // camera lines each get a flop pair; ready and data may skew by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_s1_r <= 1'b0;
      frame_s2_r <= 1'b0;
      ready_s1_r <= 1'b0;
      ready_s2_r <= 1'b0;
      data_s1_r  <= '0;
      data_s2_r  <= '0;
    end else begin
      frame_s1_r <= frame_end_input;
      frame_s2_r <= frame_s1_r;
      ready_s1_r <= camera_data_ready_in;
      ready_s2_r <= ready_s1_r;
      data_s1_r  <= parallel_data_in;
      data_s2_r  <= data_s1_r;
    end
  end

  // mode field, two bits a pad
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= MODE_RESET;
    end else if (wr && hit_mode) begin
      mode_r <= pwdata[5:0];
    end
  end

  // level register; alternate pads ignore it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= '0;
    end else if (wr && hit_out) begin
      out_r <= pwdata[NPAD-1:0];
    end
  end

  // alarm set and clear bits are strobes, only these two are stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      radio_en_r <= 1'b0;
      buzz_en_r  <= 1'b0;
    end else if (alt_wr) begin
      radio_en_r <= pwdata[ALT_RADIO_BIT];
      buzz_en_r  <= pwdata[ALT_BUZZ_EN];
    end
  end

  // camera enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cam_pwr_r    <= 1'b0;
      cam_clk_en_r <= 1'b0;
    end else if (wr && hit_cam) begin
      cam_pwr_r    <= pwdata[CAM_PWR_BIT];
      cam_clk_en_r <= pwdata[CAM_CLK_EN_BIT];
    end
  end

  // buzzer half period in pclk cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buzz_div_r <= BUZZ_DIV_RESET;
    end else if (wr && hit_div) begin
      buzz_div_r <= pwdata[DIV_W-1:0];
    end
  end

  // alarm: rises on start event, held until clear command; set wins over clear
  // a start held high keeps the pad up through a clear
  assign alarm_set = alarm_start | (alt_wr & pwdata[ALT_ALARM_SET]);
  assign alarm_clr = alt_wr & pwdata[ALT_ALARM_CLR];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_r <= 1'b0;
    end else if (alarm_set) begin
      alarm_r <= 1'b1;
    end else if (alarm_clr) begin
      alarm_r <= 1'b0;
    end
  end

  // buzzer square wave; divider reload keeps tone pitch software set
  // a divider of one toggles on every edge; zero wraps the counter and toggles every 65536 cycles
  assign buzz_wrap = (buzz_cnt_r >= buzz_div_r - DIV_W'(1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buzz_r     <= 1'b0;
      buzz_cnt_r <= '0;
    end else if (!buzz_en_r) begin
      buzz_r     <= 1'b0;
      buzz_cnt_r <= '0;
    end else if (buzz_wrap) begin
      buzz_r     <= ~buzz_r;
      buzz_cnt_r <= '0;
    end else begin
      buzz_cnt_r <= buzz_cnt_r + DIV_W'(1);
    end
  end

  // camera master clock divided from pclk
  assign cam_wrap = (cam_cnt_r == DIV_W'(CAM_HALF_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cam_clk_r <= 1'b0;
      cam_cnt_r <= '0;
    end else if (!cam_clk_en_r) begin
      cam_clk_r <= 1'b0;
      cam_cnt_r <= '0;
    end else if (cam_wrap) begin
      cam_clk_r <= ~cam_clk_r;
      cam_cnt_r <= '0;
    end else begin
      cam_cnt_r <= cam_cnt_r + DIV_W'(1);
    end
  end

  // frame end edge is sticky until status read; a new edge wins over the read clear
  assign frame_rise = frame_s2_r & ~frame_d_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_d_r    <= 1'b0;
      frame_seen_r <= 1'b0;
    end else begin
      frame_d_r <= frame_s2_r;
      if (frame_rise) begin
        frame_seen_r <= 1'b1;
      end else if (stat_rd) begin
        frame_seen_r <= 1'b0;
      end
    end
  end

  // a byte is taken only while ready stands, so a stalled sensor keeps the last one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cam_data_r <= '0;
    end else if (ready_s2_r) begin
      cam_data_r <= data_s2_r;
    end
  end

  assign radio_alt = radio_en_r & radio_transmit_monitor;
  assign alt_val   = {buzz_r, alarm_r, radio_alt};

  // one slice per pad: push-pull whenever output or alternate
  for (genvar i = 0; i < NPAD; i++) begin : g_pad
    logic oe_n_nxt;
    logic out_nxt;

    always_comb begin
      unique case (mode_r[2*i +: 2])
        MODE_IN: begin
          oe_n_nxt = 1'b1;
          out_nxt  = out_r[i];
        end
        MODE_ALT: begin
          oe_n_nxt = 1'b0;
          out_nxt  = alt_val[i];
        end
        default: begin
          oe_n_nxt = 1'b0;
          out_nxt  = out_r[i];
        end
      endcase
    end

    // registered pad outputs; camera users must unfit the sensor first
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pad_out[i]  <= 1'b0;
        pad_oe_n[i] <= 1'b1;
      end else begin
        pad_out[i]  <= out_nxt;
        pad_oe_n[i] <= oe_n_nxt;
      end
    end
  end

  assign camera_clock_out     = cam_clk_r;
  assign camera_power_command = cam_pwr_r;

  always_comb begin
    prdata_nxt = '0;
    unique case (paddr)
      ADDR_MODE:     prdata_nxt[5:0] = mode_r;
      ADDR_OUT:      prdata_nxt[NPAD-1:0] = out_r;
      ADDR_IN:       prdata_nxt[NPAD-1:0] = pin_s2_r;
      ADDR_ALT_CTL: begin
        prdata_nxt[ALT_RADIO_BIT]  = radio_en_r;
        prdata_nxt[ALT_BUZZ_EN]    = buzz_en_r;
        prdata_nxt[ALT_ALARM_STAT] = alarm_r;
      end
      ADDR_CAM_CTL: begin
        prdata_nxt[CAM_PWR_BIT]    = cam_pwr_r;
        prdata_nxt[CAM_CLK_EN_BIT] = cam_clk_en_r;
      end
      ADDR_CAM_STAT: begin
        prdata_nxt[7:0]            = cam_data_r;
        prdata_nxt[CAM_FRAME_BIT]  = frame_seen_r;
        prdata_nxt[CAM_READY_BIT]  = ready_s2_r;
      end
      ADDR_BUZZ_DIV: prdata_nxt[DIV_W-1:0] = buzz_div_r;
      default:       prdata_nxt = '0;
    endcase
  end

  // read data held in a flop; captured in setup so it is valid in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= prdata_nxt;
    end
  end

endmodule

/* File: testbench/mgcp_properties.sv */
// checker: port-level properties of the pad port block
`timescale 1ns/100ps
module mgcp_properties
  import mgcp_pkg::*;
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic [NPAD-1:0] pad_oe_n,
  input wire logic            camera_clock_out,
  input wire logic            camera_power_command
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  rst_pads_a: assert property ($rose(presetn) |-> &pad_oe_n && !camera_power_command)
    else $error("pads or power not idle after reset");
  mode_in_a: assert property (wr && paddr == ADDR_MODE && pwdata[1:0] == MODE_IN
    |=> ##[0:1] pad_oe_n[0]) else $error("input mode left driver on");
  mode_out_a: assert property (wr && paddr == ADDR_MODE && pwdata[1:0] == MODE_OUT
    |=> ##[0:1] !pad_oe_n[0]) else $error("output mode not driving");
  out_keep_a: assert property (wr && paddr == ADDR_OUT |=> $stable(pad_oe_n))
    else $error("level write changed direction");
  pwr_cmd_a: assert property (wr && paddr == ADDR_CAM_CTL
    |=> ##[0:1] camera_power_command == $past(pwdata[CAM_PWR_BIT], 2))
    else $error("power command not as written");
  clk_off_a: assert property (wr && paddr == ADDR_CAM_CTL && !pwdata[CAM_CLK_EN_BIT]
    |-> ##2 !camera_clock_out [*8]) else $error("camera clock runs while disabled");
  clk_rate_a: assert property ($rose(camera_clock_out) |-> !$past(camera_clock_out, 5))
    else $error("camera clock too fast");
  in_zero_a: assert property (acc && !pwrite && paddr == ADDR_IN |-> prdata[31:NPAD] == '0)
    else $error("pad level read has stray bits");
endmodule

/* File: testbench/mgcp_far_model.sv */
// far side model: external pad logic and a small camera sensor
`timescale 1ns/100ps
module mgcp_far_model
  import mgcp_pkg::*;
(
  input  wire logic            camera_clock_out,
  input  wire logic            camera_power_command,
  input  wire logic [NPAD-1:0] pad_out,
  input  wire logic [NPAD-1:0] pad_oe_n,
  input  wire logic [NPAD-1:0] ext_level,
  output logic      [NPAD-1:0] pad_in,
  output mgcp_cam_in_s         cam
);
  logic [3:0] cnt_r;
  // driven pad shows the module level, released pad the outside logic
  assign pad_in = (pad_out & ~pad_oe_n) | (ext_level & pad_oe_n);
  // sensor runs only while powered, so no clash on shared pads
  always_ff @(posedge camera_clock_out or negedge camera_power_command) begin
    if (!camera_power_command) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  assign cam.frame_end = camera_power_command & (&cnt_r);
  assign cam.data_ready = camera_power_command & cnt_r[0];
  // unpowered lines float: a pattern, never a steady last value
  assign cam.data = camera_power_command ? {4'h5, cnt_r} : {~cnt_r, cnt_r};
endmodule

/* File: testbench/mgcp_top_tb_top.sv */
// testbench top: apb-driven checks of the pad port block
`timescale 1ns/100ps
module mgcp_top_tb_top
  import mgcp_pkg::*;
;
  logic            pclk, presetn, psel, penable, pwrite, radio, alarm, pready, err, b;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic            pslverr, cclk, cpwr;
  logic [NPAD-1:0] pad_in, pad_out, pad_oe_n, ext;
  mgcp_cam_in_s    cam;
  int              fail_count, samples_checked, n;
  mgcp_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .radio_transmit_monitor(radio), .alarm_start(alarm),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .frame_end_input(cam.frame_end), .camera_data_ready_in(cam.data_ready),
    .parallel_data_in(cam.data), .camera_clock_out(cclk), .camera_power_command(cpwr));
  mgcp_far_model u_far (.camera_clock_out(cclk), .camera_power_command(cpwr),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_level(ext), .pad_in(pad_in), .cam(cam));
  task automatic final_report();
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // one transfer; idle edge first so psel is never set twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    if (k >= 16) begin
      check("apb ready", 32'h0, 32'h1);
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, radio, alarm} = '0;
    paddr = '0;
    pwdata = '0;
    ext = 3'h0;
    cyc(10);
    presetn <= 1'b1;
    apb(1'b0, ADDR_MODE, 32'h0);
    check("mode reset", rd, 32'h0);
    check("oe reset", 32'(pad_oe_n), 32'h7);
    apb(1'b0, ADDR_BUZZ_DIV, 32'h0);
    check("div reset", rd, 32'(BUZZ_DIV_RESET));
    for (int j = 5; j > 3; j--) begin
      ext <= j[2:0] ^ 3'h7;
      cyc(4);
      apb(1'b0, ADDR_IN, 32'h0);
      check("pad input", rd, 32'(j[2:0] ^ 3'h7));
    end
    apb(1'b1, ADDR_MODE, 32'h15);
    apb(1'b1, ADDR_OUT, 32'h6);
    cyc(3);
    check("out level", 32'(pad_out), 32'h6);
    check("out drive", 32'(pad_oe_n), 32'h0);
    apb(1'b0, ADDR_OUT, 32'h0);
    check("out query", rd, 32'h6);
    apb(1'b0, ADDR_IN, 32'h0);
    check("out on pad", rd, 32'h6);
    apb(1'b1, ADDR_MODE, 32'h2A);
    apb(1'b1, ADDR_ALT_CTL, 32'h1);
    radio <= 1'b1;
    cyc(4);
    check("radio high", 32'(pad_out[0]), 32'h1);
    radio <= 1'b0;
    apb(1'b1, ADDR_OUT, 32'h7);
    cyc(3);
    check("alt ignores write", 32'(pad_out[1:0]), 32'h0);
    alarm <= 1'b1;
    cyc(1);
    alarm <= 1'b0;
    cyc(30);
    check("alarm held", 32'(pad_out[1]), 32'h1);
    apb(1'b0, ADDR_ALT_CTL, 32'h0);
    check("alarm status", 32'(rd[ALT_ALARM_STAT]), 32'h1);
    apb(1'b1, ADDR_ALT_CTL, 32'h5);
    cyc(3);
    check("alarm cleared", 32'(pad_out[1]), 32'h0);
    apb(1'b1, ADDR_BUZZ_DIV, 32'h4);
    apb(1'b1, ADDR_ALT_CTL, 32'h9);
    for (int j = 0; j < 3; j++) begin
      b = pad_out[2];
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (pad_out[2] === b && n < 99);
    end
    check("buzz half period", 32'(n), 32'h4);
    apb(1'b1, ADDR_CAM_CTL, 32'h3);
    cyc(3);
    check("cam power", 32'(cpwr), 32'h1);
    cyc(200);
    apb(1'b0, ADDR_CAM_STAT, 32'h0);
    check("frame end", 32'(rd[CAM_FRAME_BIT]), 32'h1);
    check("cam data", 32'(rd[7:4]), 32'h5);
    apb(1'b0, ADDR_CAM_STAT, 32'h0);
    check("frame cleared", 32'(rd[CAM_FRAME_BIT]), 32'h0);
    apb(1'b1, ADDR_CAM_CTL, 32'h0);
    cyc(12);
    apb(1'b1, ADDR_MODE, 32'h0);
    cyc(2);
    check("in mode oe", 32'(pad_oe_n), 32'h7);
    apb(1'b0, 12'h01C, 32'h0);
    check("unmapped err", 32'(err), 32'h1);
    check("unmapped data", rd, 32'h0);
    final_report();
  end
endmodule
bind mgcp_top mgcp_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pad_oe_n(pad_oe_n), .camera_clock_out(camera_clock_out),
  .camera_power_command(camera_power_command));
